/* inc/dre_pkg.sv */
package dre_pkg;

	// Bus and bitmap widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CH_N   = 16;
	localparam int CH_W   = 4;
	localparam int CMD_N  = 4;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ERQ_ADDR  = 8'h0C;
	localparam logic [ADDR_W-1:0] EEI_ADDR  = 8'h14;
	localparam logic [ADDR_W-1:0] CMD_ADDR  = 8'h18;
	localparam logic [ADDR_W-1:0] SET_REQUEST_CHANNEL_FIELD_ADDR = 8'h18;
	localparam logic [ADDR_W-1:0] CLEAR_REQUEST_CHANNEL_FIELD_ADDR = 8'h19;
	localparam logic [ADDR_W-1:0] SET_ERROR_ENABLE_CHANNEL_FIELD_ADDR = 8'h1A;
	localparam logic [ADDR_W-1:0] CLEAR_ERROR_ENABLE_CHANNEL_FIELD_ADDR = 8'h1B;

	// Command byte lanes inside the command word, lowest byte address highest
	localparam int SET_REQUEST_CHANNEL_FIELD_LANE = 0;
	localparam int CLEAR_REQUEST_CHANNEL_FIELD_LANE = 1;
	localparam int SET_ERROR_ENABLE_CHANNEL_FIELD_LANE = 2;
	localparam int CLEAR_ERROR_ENABLE_CHANNEL_FIELD_LANE = 3;

	// Command byte fields
	localparam int NOP_BIT  = 7;
	localparam int ALL_BIT  = 6;
	localparam int RSV_HI   = 5;
	localparam int RSV_LO   = 4;
	localparam int CHAN_HI  = 3;
	localparam int CHAN_LO  = 0;

	// Reset and constant values
	localparam logic [CH_N-1:0]   BITMAP_RST = 16'h0000;
	localparam logic [CH_N-1:0]   BITMAP_ALL = 16'hFFFF;
	localparam logic [CH_N-1:0]   CHAN_ONE   = 16'h0001;
	localparam logic [DATA_W-1:0] READ_ZERO  = 32'h0000_0000;

endpackage

/* rtl/dre_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module dre_cmd_decode
	import dre_pkg::*;
(
	// Command byte
	input  wire logic            cmd_wr_i,
	input  wire logic [7:0]      cmd_byte_i,
	// Channel mask
	output logic      [CH_N-1:0] mask_o
);

	logic single;

	// Bits 5 and 4 must be zero; otherwise the value is reserved
	assign single = (cmd_byte_i[RSV_HI:RSV_LO] == 2'h0);

	always_comb
	begin
		mask_o = BITMAP_RST;
		if (cmd_wr_i && !cmd_byte_i[NOP_BIT])
		begin
			if (cmd_byte_i[ALL_BIT])
				mask_o = BITMAP_ALL;
			else if (single)
				mask_o = CHAN_ONE << cmd_byte_i[CHAN_HI:CHAN_LO];
		end
	end

endmodule

`default_nettype wire

/* rtl/dre_regs.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dre_regs
	import dre_pkg::*;
(
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	// Channel requests
	input  wire logic [CH_N-1:0]   hw_req_i,
	input  wire logic [CH_N-1:0]   sw_start_i,
	output logic      [CH_N-1:0]   service_req_o,
	// Major loop completion
	input  wire logic [CH_N-1:0]   major_done_i,
	input  wire logic [CH_N-1:0]   disable_on_done_i,
	// Error interrupts
	input  wire logic [CH_N-1:0]   err_ind_i,
	output logic      [CH_N-1:0]   err_irq_o
);

	logic [CH_N-1:0] request_enable_bitmap;
	logic [CH_N-1:0] error_irq_enable_bitmap;
	logic [CH_N-1:0] next_request_enable_bitmap;
	logic [CH_N-1:0] next_error_irq_enable_bitmap;
	logic [CH_N-1:0] cmd_mask [CMD_N];
	logic [CH_N-1:0] done_clear;
	logic            erq_wr;
	logic            eei_wr;
	logic            cmd_wr;

	// Word decode; low address bits are ignored, so byte addresses of the
	// command lanes all land in the one command word
	assign erq_wr = wr_i && (addr_i[ADDR_W-1:2] == ERQ_ADDR[ADDR_W-1:2]);
	assign eei_wr = wr_i && (addr_i[ADDR_W-1:2] == EEI_ADDR[ADDR_W-1:2]);
	assign cmd_wr = wr_i && (addr_i[ADDR_W-1:2] == CMD_ADDR[ADDR_W-1:2]);

	// One decoder per command byte lane
	genvar k;
	generate
		for (k = 0; k < CMD_N; k++)
		begin : g_cmd
			dre_cmd_decode u_dec
			(
				.cmd_wr_i   (cmd_wr),
				.cmd_byte_i (wdata_i[DATA_W-1-8*k -: 8]),
				.mask_o     (cmd_mask[k])
			);
		end
	endgenerate

	assign done_clear = major_done_i & disable_on_done_i;

	// Set applies before clear, so a word that sets and clears one
	// channel leaves it clear; completion clears last of all
	always_comb
	begin
		next_request_enable_bitmap = request_enable_bitmap;
		if (erq_wr)
			next_request_enable_bitmap = wdata_i[CH_N-1:0];
		next_request_enable_bitmap = next_request_enable_bitmap | cmd_mask[SET_REQUEST_CHANNEL_FIELD_LANE];
		next_request_enable_bitmap = next_request_enable_bitmap & ~cmd_mask[CLEAR_REQUEST_CHANNEL_FIELD_LANE];
		next_request_enable_bitmap = next_request_enable_bitmap & ~done_clear;
	end

	always_comb
	begin
		next_error_irq_enable_bitmap = error_irq_enable_bitmap;
		if (eei_wr)
			next_error_irq_enable_bitmap = wdata_i[CH_N-1:0];
		next_error_irq_enable_bitmap = next_error_irq_enable_bitmap | cmd_mask[SET_ERROR_ENABLE_CHANNEL_FIELD_LANE];
		next_error_irq_enable_bitmap = next_error_irq_enable_bitmap & ~cmd_mask[CLEAR_ERROR_ENABLE_CHANNEL_FIELD_LANE];
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			request_enable_bitmap <= BITMAP_RST;
		else
			request_enable_bitmap <= next_request_enable_bitmap;
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			error_irq_enable_bitmap <= BITMAP_RST;
		else
			error_irq_enable_bitmap <= next_error_irq_enable_bitmap;
	end

	// Request qualification; software starts skip the gate
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			service_req_o <= BITMAP_RST;
		else
			service_req_o <= (hw_req_i & request_enable_bitmap) | sw_start_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			err_irq_o <= BITMAP_RST;
		else
			err_irq_o <= err_ind_i & error_irq_enable_bitmap;
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			rdata_o <= READ_ZERO;
		else if (rd_i && (addr_i[ADDR_W-1:2] == ERQ_ADDR[ADDR_W-1:2]))
			rdata_o <= {16'h0000, request_enable_bitmap};
		else if (rd_i && (addr_i[ADDR_W-1:2] == EEI_ADDR[ADDR_W-1:2]))
			rdata_o <= {16'h0000, error_irq_enable_bitmap};
		else
			rdata_o <= READ_ZERO;
	end

	// Helper terms for the checks below
	logic [7:0] a_set_request_channel_field;
	logic [7:0] a_clear_request_channel_field;
	logic [7:0] a_set_error_enable_channel_field;
	logic [7:0] a_clear_error_enable_channel_field;
	logic       a_no_done;
	assign a_set_request_channel_field    = wdata_i[DATA_W-1-8*SET_REQUEST_CHANNEL_FIELD_LANE -: 8];
	assign a_clear_request_channel_field    = wdata_i[DATA_W-1-8*CLEAR_REQUEST_CHANNEL_FIELD_LANE -: 8];
	assign a_set_error_enable_channel_field    = wdata_i[DATA_W-1-8*SET_ERROR_ENABLE_CHANNEL_FIELD_LANE -: 8];
	assign a_clear_error_enable_channel_field    = wdata_i[DATA_W-1-8*CLEAR_ERROR_ENABLE_CHANNEL_FIELD_LANE -: 8];
	assign a_no_done = (done_clear == BITMAP_RST);

	a_reset_zero: assert property (
		@(posedge clock_i)
		$fell(sys_rst_i) |-> (request_enable_bitmap == BITMAP_RST)
			&& (error_irq_enable_bitmap == BITMAP_RST))
		else $error("Bitmaps not zero after reset");

	a_erq_direct: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		erq_wr && a_no_done |=> request_enable_bitmap == $past(wdata_i[CH_N-1:0]))
		else $error("Direct write lost in request enables");

	a_eei_direct: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		eei_wr |=> error_irq_enable_bitmap == $past(wdata_i[CH_N-1:0]))
		else $error("Direct write lost in error enables");

	a_hw_gate: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> (service_req_o & ~$past(sw_start_i))
			== ($past(hw_req_i) & $past(request_enable_bitmap) & ~$past(sw_start_i)))
		else $error("Hardware request gating wrong");

	a_sw_bypass: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		(sw_start_i != BITMAP_RST) |=> (service_req_o & $past(sw_start_i)) == $past(sw_start_i))
		else $error("Software start blocked");

	a_err_gate: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> err_irq_o == ($past(err_ind_i) & $past(error_irq_enable_bitmap)))
		else $error("Error interrupt gating wrong");

	a_done_clear: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!a_no_done |=> (request_enable_bitmap & $past(done_clear)) == BITMAP_RST)
		else $error("Completion did not clear enable");

	a_done_keep: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!wr_i && (major_done_i != BITMAP_RST) && (disable_on_done_i == BITMAP_RST)
			|=> $stable(request_enable_bitmap))
		else $error("Completion changed enable without flag");

	a_set_one: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && (a_set_request_channel_field[7:4] == 4'h0) && a_clear_request_channel_field[NOP_BIT]
			|=> request_enable_bitmap
				== ($past(request_enable_bitmap) | (CHAN_ONE << $past(a_set_request_channel_field[3:0]))))
		else $error("Single set of request enable wrong");

	a_set_all: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && (a_set_request_channel_field[7:6] == 2'h1) && a_clear_request_channel_field[NOP_BIT]
			|=> request_enable_bitmap == BITMAP_ALL)
		else $error("Global set of request enable wrong");

	a_clr_one: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && (a_clear_request_channel_field[7:4] == 4'h0) && a_set_request_channel_field[NOP_BIT]
			|=> request_enable_bitmap
				== ($past(request_enable_bitmap) & ~(CHAN_ONE << $past(a_clear_request_channel_field[3:0]))))
		else $error("Single clear of request enable wrong");

	a_clr_all: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && (a_clear_request_channel_field[7:6] == 2'h1) |=> request_enable_bitmap == BITMAP_RST)
		else $error("Global clear of request enable wrong");

	a_eei_set_one: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && (a_set_error_enable_channel_field[7:4] == 4'h0) && a_clear_error_enable_channel_field[NOP_BIT]
			|=> error_irq_enable_bitmap[$past(a_set_error_enable_channel_field[3:0])])
		else $error("Single set of error enable wrong");

	a_eei_set_all: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && (a_set_error_enable_channel_field[7:6] == 2'h1) && a_clear_error_enable_channel_field[NOP_BIT]
			|=> error_irq_enable_bitmap == BITMAP_ALL)
		else $error("Global set of error enable wrong");

	a_eei_clr_one: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && (a_clear_error_enable_channel_field[7:4] == 4'h0)
			|=> !error_irq_enable_bitmap[$past(a_clear_error_enable_channel_field[3:0])])
		else $error("Single clear of error enable wrong");

	a_eei_clr_all: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && (a_clear_error_enable_channel_field[7:6] == 2'h1) |=> error_irq_enable_bitmap == BITMAP_RST)
		else $error("Global clear of error enable wrong");

	a_nop_hold: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && a_set_request_channel_field[NOP_BIT] && a_clear_request_channel_field[NOP_BIT]
			&& a_set_error_enable_channel_field[NOP_BIT] && a_clear_error_enable_channel_field[NOP_BIT]
			|=> $stable(request_enable_bitmap) && $stable(error_irq_enable_bitmap))
		else $error("No-operation byte changed a bitmap");

	a_rsvd_hold: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && a_set_request_channel_field[NOP_BIT]
			&& (a_clear_request_channel_field[7:6] == 2'h0) && (a_clear_request_channel_field[5:4] != 2'h0)
			&& (a_set_error_enable_channel_field[7:6] == 2'h0) && (a_set_error_enable_channel_field[5:4] != 2'h0)
			&& (a_clear_error_enable_channel_field[7:6] == 2'h0) && (a_clear_error_enable_channel_field[5:4] != 2'h0)
			|=> $stable(request_enable_bitmap) && $stable(error_irq_enable_bitmap))
		else $error("Reserved command changed a bitmap");

	a_lanes_apart: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		cmd_wr && a_no_done && (a_set_request_channel_field[7:6] == 2'h1) && (a_clear_error_enable_channel_field[7:6] == 2'h1)
			&& a_clear_request_channel_field[NOP_BIT] && a_set_error_enable_channel_field[NOP_BIT]
			|=> (request_enable_bitmap == BITMAP_ALL)
				&& (error_irq_enable_bitmap == BITMAP_RST))
		else $error("Command lanes interfere");

	a_cmd_read: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		rd_i && (addr_i[ADDR_W-1:2] == CMD_ADDR[ADDR_W-1:2]) |=> rdata_o == READ_ZERO)
		else $error("Command register read not zero");

	a_bitmap_read: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		rd_i && (addr_i[ADDR_W-1:2] == ERQ_ADDR[ADDR_W-1:2])
			|=> rdata_o == {16'h0000, $past(request_enable_bitmap)} ##1 rdata_o == READ_ZERO
			|| $past(rd_i))
		else $error("Request enable readback wrong");

	a_eei_read: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		rd_i && (addr_i[ADDR_W-1:2] == EEI_ADDR[ADDR_W-1:2])
			|=> rdata_o == {16'h0000, $past(error_irq_enable_bitmap)})
		else $error("Error enable readback wrong");

	a_outs_reset: assert property (
		@(posedge clock_i)
		sys_rst_i |=> (service_req_o == BITMAP_RST) && (err_irq_o == BITMAP_RST)
			&& (rdata_o == READ_ZERO))
		else $error("Outputs not zero after reset");

	a_erq_hold: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!erq_wr && !cmd_wr && a_no_done |=> $stable(request_enable_bitmap))
		else $error("Request enables changed without cause");

	a_eei_hold: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		!eei_wr && !cmd_wr |=> $stable(error_irq_enable_bitmap))
		else $error("Error enables changed without cause");

	a_upper_zero: assert property (
		@(posedge clock_i) disable iff (sys_rst_i)
		rdata_o[DATA_W-1:CH_N] == 16'h0000)
		else $error("Upper read data not zero");

endmodule

`default_nettype wire

/* tb/dre_chan_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dre_chan_model
	import dre_pkg::*;
(
	// Clock
	input  wire logic            clock_i,
	// Patterns from the bench
	input  wire logic [CH_N-1:0] req_pat_i,
	input  wire logic [CH_N-1:0] start_pat_i,
	input  wire logic [CH_N-1:0] err_pat_i,
	input  wire logic [CH_N-1:0] done_pat_i,
	input  wire logic [CH_N-1:0] dod_pat_i,
	// Lines into the block
	output logic      [CH_N-1:0] hw_req_o,
	output logic      [CH_N-1:0] sw_start_o,
	output logic      [CH_N-1:0] err_ind_o,
	output logic      [CH_N-1:0] major_done_o,
	output logic      [CH_N-1:0] dod_o
);
	// Registered, like the real sources, so lines move only after an edge
	always_ff @(posedge clock_i)
	begin
		hw_req_o     <= req_pat_i;
		sw_start_o   <= start_pat_i;
		err_ind_o    <= err_pat_i;
		major_done_o <= done_pat_i;
		dod_o        <= dod_pat_i;
	end
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import dre_pkg::*;
	logic              clock_i = 1'h0;
	logic              sys_rst_i = 1'h1;
	logic [ADDR_W-1:0] addr_i = 8'h00;
	logic [DATA_W-1:0] wdata_i = 32'h0000_0000;
	logic              wr_i = 1'h0;
	logic              rd_i = 1'h0;
	logic [DATA_W-1:0] rdata_o;
	logic [CH_N-1:0]   req_pat = 16'h0000, start_pat = 16'h0000, err_pat = 16'h0000;
	logic [CH_N-1:0]   done_pat = 16'h0000, dod_pat = 16'h0000;
	logic [CH_N-1:0]   erq, eei;
	wire logic [CH_N-1:0] hw_req, sw_start, err_ind, major_done, dod, svc, irq;
	int                n_fail = 0;
	int                checks_done = 0;

	always #50 clock_i = ~clock_i;

	dre_chan_model src (.clock_i(clock_i), .req_pat_i(req_pat), .start_pat_i(start_pat),
		.err_pat_i(err_pat), .done_pat_i(done_pat), .dod_pat_i(dod_pat), .hw_req_o(hw_req),
		.sw_start_o(sw_start), .err_ind_o(err_ind), .major_done_o(major_done), .dod_o(dod));

	dre_regs dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_req_i(hw_req),
		.sw_start_i(sw_start), .service_req_o(svc), .major_done_i(major_done),
		.disable_on_done_i(dod), .err_ind_i(err_ind), .err_irq_o(irq));

	task automatic chk(input string name, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask

	// Read data stand one cycle only, so sample just after the edge
	task automatic rd(input logic [ADDR_W-1:0] a, input string name,
		input logic [DATA_W-1:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1 chk(name, exp, rdata_o);
	endtask

	task automatic maps();
		rd(ERQ_ADDR, "request enables", {16'h0000, erq});
		rd(EEI_ADDR, "error enables", {16'h0000, eei});
	endtask

	// Partner register plus design register: two edges of latency
	task automatic outs();
		repeat (2) @(posedge clock_i);
		#1 chk("service requests", {16'h0000, (req_pat & erq) | start_pat}, {16'h0000, svc});
		chk("error irqs", {16'h0000, err_pat & eei}, {16'h0000, irq});
	endtask

	task automatic t_reset();
		erq = BITMAP_RST;
		eei = BITMAP_RST;
		maps();
		outs();
	endtask

	task automatic t_direct();
		wr(ERQ_ADDR, 32'hFFFF_A5C3);
		wr(EEI_ADDR, 32'h1234_5A3C);
		erq = 16'hA5C3;
		eei = 16'h5A3C;
		maps();
	endtask

	task automatic t_single();
		wr(CMD_ADDR, 32'h0C00_0102);
		erq = (erq | (CHAN_ONE << 12)) & ~CHAN_ONE;
		eei = (eei | (CHAN_ONE << 1)) & ~(CHAN_ONE << 2);
		maps();
		wr(CMD_ADDR, 32'h0580_8080);
		wr(CMD_ADDR, 32'h800C_8080);
		erq = (erq | (CHAN_ONE << 5)) & ~(CHAN_ONE << 12);
		maps();
		wr(CMD_ADDR, 32'h8F8F_8F8F);
		maps();
		wr(CMD_ADDR, 32'h8080_0380);
		eei = eei | (CHAN_ONE << 3);
		maps();
	endtask

	task automatic t_all();
		wr(CMD_ADDR, 32'h4080_7F80);
		erq = BITMAP_ALL;
		eei = BITMAP_ALL;
		maps();
		wr(CMD_ADDR, 32'h807F_8041);
		erq = BITMAP_RST;
		eei = BITMAP_RST;
		maps();
		wr(CMD_ADDR, 32'h4080_8040);
		erq = BITMAP_ALL;
		eei = BITMAP_RST;
		maps();
	endtask

	// Software must not send these; the block has to shrug them off
	task automatic t_reserved();
		wr(ERQ_ADDR, 32'h0000_00FF);
		wr(EEI_ADDR, 32'h0000_0F0F);
		erq = 16'h00FF;
		eei = 16'h0F0F;
		wr(CMD_ADDR, 32'h8010_3F25);
		maps();
	endtask

	task automatic t_cmd_read();
		rd(CMD_ADDR, "command word", READ_ZERO);
		rd(SET_ERROR_ENABLE_CHANNEL_FIELD_ADDR, "command byte", READ_ZERO);
		rd(8'h40, "unmapped", READ_ZERO);
	endtask

	task automatic t_chan();
		@(posedge clock_i);
		req_pat <= BITMAP_ALL;
		start_pat <= 16'h3000;
		err_pat <= 16'hFFF0;
		outs();
	endtask

	task automatic t_done();
		wr(ERQ_ADDR, 32'h0000_FFFF);
		@(posedge clock_i);
		done_pat <= 16'h0011;
		dod_pat <= 16'h0001;
		@(posedge clock_i);
		done_pat <= 16'h0000;
		dod_pat <= 16'h0000;
		erq = 16'hFFFE;
		// Completion without the flag must leave the enable alone
		@(posedge clock_i);
		done_pat <= 16'h0100;
		@(posedge clock_i);
		done_pat <= 16'h0000;
		repeat (2) @(posedge clock_i);
		maps();
	endtask

	task automatic t_mid_reset();
		@(posedge clock_i);
		sys_rst_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		#1 chk("outputs in reset", READ_ZERO, {svc, irq});
		@(posedge clock_i);
		sys_rst_i <= 1'h0;
		erq = BITMAP_RST;
		eei = BITMAP_RST;
		maps();
		outs();
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clock_i);
		n_fail++;
		end_of_test();
	end

	initial
	begin
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		t_reset();
		t_direct();
		t_single();
		t_all();
		t_reserved();
		t_cmd_read();
		t_chan();
		t_done();
		t_mid_reset();
		end_of_test();
	end
endmodule

`default_nettype wire
